// *** core/tmr_pkg.sv ***
// Constants and types shared by the temperature monitor register file
package tmr_pkg;

  // ************************************************************
  // Selector and fixed addresses
  // ************************************************************
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] A_LT_UP = 8'h00;
  localparam logic [7:0] A_RT_UP = 8'h01;
  localparam logic [7:0] A_STATUS = 8'h02;
  localparam logic [7:0] A_CFG_RD = 8'h03;
  localparam logic [7:0] A_RATE_RD = 8'h04;
  localparam logic [7:0] A_LHI_RD = 8'h05;
  localparam logic [7:0] A_LLO_RD = 8'h06;
  localparam logic [7:0] A_RHI_RD = 8'h07;
  localparam logic [7:0] A_RLO_RD = 8'h08;
  localparam logic [7:0] A_CFG_WR = 8'h09;
  localparam logic [7:0] A_RATE_WR = 8'h0A;
  localparam logic [7:0] A_LHI_WR = 8'h0B;
  localparam logic [7:0] A_LLO_WR = 8'h0C;
  localparam logic [7:0] A_RHI_WR = 8'h0D;
  localparam logic [7:0] A_RLO_WR = 8'h0E;
  localparam logic [7:0] A_ONESHOT = 8'h0F;
  localparam logic [7:0] A_RT_LO = 8'h10;
  localparam logic [7:0] A_RHI_LO = 8'h13;
  localparam logic [7:0] A_RLO_LO = 8'h14;
  localparam logic [7:0] A_LT_LO = 8'h15;
  localparam logic [7:0] A_LHI_LO = 8'h16;
  localparam logic [7:0] A_LLO_LO = 8'h17;
  localparam logic [7:0] A_RCRIT = 8'h19;
  localparam logic [7:0] A_RES = 8'h1A;
  localparam logic [7:0] A_LCRIT = 8'h20;
  localparam logic [7:0] A_HYST = 8'h21;
  localparam logic [7:0] A_CONSEC = 8'h22;
  localparam logic [7:0] A_MAKER = 8'hFE;
  localparam logic [7:0] A_PART = 8'hFF;
  // Read-only target used when a byte has no writable partner
  localparam logic [7:0] A_NO_WRITE = 8'h00;

  // ************************************************************
  // Temperature results and configuration fields
  // ************************************************************
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] TEMP_LO_MASK = 8'hF0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int CFG_SHUTDOWN_BIT = 6;
  localparam int CFG_RANGE_BIT = 2;

  // ************************************************************
  // Table of the plain read/write byte registers
  // ************************************************************
  localparam int NREG = 15;
  localparam int R_LHI_U = 0;
  localparam int R_LLO_U = 1;
  localparam int R_RHI_U = 2;
  localparam int R_RLO_U = 3;
  localparam int R_LHI_L = 4;
  localparam int R_LLO_L = 5;
  localparam int R_RHI_L = 6;
  localparam int R_RLO_L = 7;
  localparam int R_RCRIT = 8;
  localparam int R_LCRIT = 9;
  localparam int R_HYST = 10;
  localparam int R_CFG = 11;
  localparam int R_RATE = 12;
  localparam int R_RES = 13;
  localparam int R_CONSEC = 14;
  localparam logic [7:0] REG_WADDR [NREG] = '{A_LHI_WR, A_LLO_WR, A_RHI_WR, A_RLO_WR, A_LHI_LO, A_LLO_LO,
    A_RHI_LO, A_RLO_LO, A_RCRIT, A_LCRIT, A_HYST, A_CFG_WR, A_RATE_WR, A_RES, A_CONSEC};
  localparam logic [7:0] REG_RADDR [NREG] = '{A_LHI_RD, A_LLO_RD, A_RHI_RD, A_RLO_RD, A_LHI_LO, A_LLO_LO,
    A_RHI_LO, A_RLO_LO, A_RCRIT, A_LCRIT, A_HYST, A_CFG_RD, A_RATE_RD, A_RES, A_CONSEC};
  localparam logic [7:0] REG_RESET [NREG] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h55, 8'h55, 8'h0A, 8'h00, 8'h08, 8'h1C, 8'h80};
  localparam logic [7:0] REG_WMASK [NREG] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'hF0,
    8'hF0, 8'hF0, 8'hFF, 8'hFF, 8'hFF, 8'hE4, 8'h0F, 8'h03, 8'h8E};

  // ************************************************************
  // Command phases
  // ************************************************************
  typedef enum logic [1:0] {WR_IDLE, WR_UPPER, WR_LOWER, WR_EXTRA} tmr_wr_phase_t;

endpackage

// *** core/tmr_byte_reg.sv ***
// One read/write byte register with fixed bits and a reset value
`timescale 1ns/1ps
`default_nettype none
module tmr_byte_reg
  import tmr_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] q_out
);

  typedef struct packed {
    logic [7:0] val;
  } tmr_byte_state_t;

  tmr_byte_state_t st_q;
  tmr_byte_state_t st_d;

  // Bits outside the mask keep their reset value, so they read back fixed
  always_comb begin
    st_d = st_q;
    if (wr_en_in) begin
      st_d.val = (wr_data_in & WMASK) | (RESET_VAL & ~WMASK);
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q.val <= RESET_VAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.val;

endmodule
`default_nettype wire

// *** core/tmr_regs.sv ***
// Register file of the remote/local temperature monitor behind the pointer
`timescale 1ns/1ps
`default_nettype none
module tmr_regs
  import tmr_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3C   // Arbitrary value
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic wr_valid_in,
  input wire logic wr_first_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_req_in,
  input wire logic rd_first_in,
  input wire logic conv_done_in,
  input wire logic conv_remote_in,
  input wire logic [7:0] conv_upper_in,
  input wire logic [7:0] conv_lower_in,
  input wire logic [7:0] flag_status_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic one_shot_out,
  output logic status_read_out,
  output logic shutdown_bit_out,
  output logic range_out,
  output logic [NREG*8-1:0] reg_file_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] sel;
    tmr_wr_phase_t wr_phase;
    logic rd_second;
    logic [1:0][7:0] temp_up;
    logic [1:0][7:0] temp_lo;
    logic [7:0] snap_lo;
    logic snap_remote;
    logic snap_ok;
    logic [7:0] rd_data;
    logic rd_valid;
    logic one_shot;
    logic status_read;
  } tmr_state_t;

  tmr_state_t st_q;
  tmr_state_t st_d;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [7:0] rd_byte;
  logic [7:0] reg_q [NREG];

  // Lower byte written by the third byte of a two-byte limit write
  function automatic logic [7:0] wr_partner(input logic [7:0] sel);
    logic [7:0] p;
    p = A_NO_WRITE;
    unique case (sel)
      A_LHI_WR: p = A_LHI_LO;
      A_LLO_WR: p = A_LLO_LO;
      A_RHI_WR: p = A_RHI_LO;
      A_RLO_WR: p = A_RLO_LO;
      default: p = A_NO_WRITE;
    endcase
    return p;
  endfunction

  // Lower byte returned as the second byte of a two-byte read
  function automatic logic [7:0] rd_partner(input logic [7:0] sel);
    logic [7:0] p;
    p = sel;
    unique case (sel)
      A_LT_UP: p = A_LT_LO;
      A_RT_UP: p = A_RT_LO;
      A_LHI_RD: p = A_LHI_LO;
      A_LLO_RD: p = A_LLO_LO;
      A_RHI_RD: p = A_RHI_LO;
      A_RLO_RD: p = A_RLO_LO;
      default: p = sel;
    endcase
    return p;
  endfunction

  // ************************************************************
  // Byte registers
  // ************************************************************
  // Range bit lives in the configuration byte only; limits never reformat
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    logic hit;
    assign hit = wr_fire && (wr_addr == REG_WADDR[i]);
    tmr_byte_reg #(
      .RESET_VAL(REG_RESET[i]),
      .WMASK(REG_WMASK[i])
    ) u_reg (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .wr_en_in(hit),
      .wr_data_in(wr_data_in),
      .q_out(reg_q[i])
    );
    assign reg_file_out[i*8 +: 8] = reg_q[i];
  end

  // ************************************************************
  // Command handling
  // ************************************************************
  // Write bytes, read mux, pairing snapshot and result capture
  always_comb begin
    st_d = st_q;
    st_d.rd_valid = 1'b0;
    st_d.one_shot = 1'b0;
    st_d.status_read = 1'b0;
    wr_fire = 1'b0;
    wr_addr = A_NO_WRITE;
    rd_byte = UNMAPPED_READ;

    // First byte is the selector; bytes before any selector are dropped
    if (wr_valid_in) begin
      if (wr_first_in) begin
        st_d.sel = wr_data_in;
        st_d.wr_phase = WR_UPPER;
      end else begin
        unique case (st_q.wr_phase)
          WR_UPPER: begin
            wr_fire = 1'b1;
            wr_addr = st_q.sel;
            st_d.wr_phase = WR_LOWER;
          end
          WR_LOWER: begin
            wr_fire = 1'b1;
            wr_addr = wr_partner(st_q.sel);
            st_d.wr_phase = WR_EXTRA;
          end
          WR_IDLE, WR_EXTRA: begin
            wr_fire = 1'b0;
          end
        endcase
      end
    end

    // A one-shot while running is swallowed; the sequencer is already busy
    if (wr_fire && (wr_addr == A_ONESHOT) && reg_q[R_CFG][CFG_SHUTDOWN_BIT]) begin
      st_d.one_shot = 1'b1;
    end

    // Second byte of a command follows the pair; later bytes repeat the selector
    rd_addr = (rd_first_in || !st_q.rd_second) ? st_q.sel : rd_partner(st_q.sel);
    for (int i = 0; i < NREG; i++) begin
      if (rd_addr == REG_RADDR[i]) begin
        rd_byte = reg_q[i];
      end
    end
    unique case (rd_addr)
      A_LT_UP: rd_byte = st_q.temp_up[0];
      A_RT_UP: rd_byte = st_q.temp_up[1];
      A_LT_LO: begin
        rd_byte = (st_q.snap_ok && !st_q.snap_remote) ? st_q.snap_lo : st_q.temp_lo[0];
      end
      A_RT_LO: begin
        rd_byte = (st_q.snap_ok && st_q.snap_remote) ? st_q.snap_lo : st_q.temp_lo[1];
      end
      A_STATUS: rd_byte = flag_status_in;
      A_MAKER: rd_byte = MAKER_CODE;
      A_PART: rd_byte = PART_CODE;
      default: rd_byte = rd_byte;
    endcase

    // Snapshot the lower byte at the upper read; any other read ends it
    // A conversion landing with the upper read stays out, so the pair remains coherent
    if (rd_req_in) begin
      st_d.rd_valid = 1'b1;
      st_d.rd_data = rd_byte;
      st_d.rd_second = rd_first_in;
      st_d.status_read = (rd_addr == A_STATUS);
      if (rd_addr == A_LT_UP || rd_addr == A_RT_UP) begin
        st_d.snap_remote = (rd_addr == A_RT_UP);
        st_d.snap_lo = st_q.temp_lo[rd_addr == A_RT_UP];
        st_d.snap_ok = 1'b1;
      end else begin
        st_d.snap_ok = 1'b0;
      end
    end

    // Results only change through the converter, never by bus writes
    if (conv_done_in) begin
      st_d.temp_up[conv_remote_in] = conv_upper_in;
      st_d.temp_lo[conv_remote_in] = conv_lower_in & TEMP_LO_MASK;
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q.sel <= SEL_RESET;
      st_q.wr_phase <= WR_IDLE;
      st_q.rd_second <= 1'b0;
      st_q.temp_up <= {TEMP_RESET, TEMP_RESET};
      st_q.temp_lo <= {TEMP_RESET, TEMP_RESET};
      st_q.snap_lo <= TEMP_RESET;
      st_q.snap_remote <= 1'b0;
      st_q.snap_ok <= 1'b0;
      st_q.rd_data <= UNMAPPED_READ;
      st_q.rd_valid <= 1'b0;
      st_q.one_shot <= 1'b0;
      st_q.status_read <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rd_data_out = st_q.rd_data;
  assign rd_valid_out = st_q.rd_valid;
  assign one_shot_out = st_q.one_shot;
  assign status_read_out = st_q.status_read;
  // Levels come straight from the configuration flops, with no extra delay
  assign shutdown_bit_out = reg_q[R_CFG][CFG_SHUTDOWN_BIT];
  assign range_out = reg_q[R_CFG][CFG_RANGE_BIT];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  // Selector loads only from a command's first byte
  sel_load_a: assert property (wr_valid_in && wr_first_in |=> st_q.sel == $past(wr_data_in))
    else $error("selector not loaded by first write byte");
  sel_hold_a: assert property (!(wr_valid_in && wr_first_in) |=> $stable(st_q.sel))
    else $error("selector changed without a first write byte");

  // Result capture from the converter
  temp_update_a: assert property (conv_done_in |=>
    st_q.temp_up[$past(conv_remote_in)] == $past(conv_upper_in) &&
    st_q.temp_lo[$past(conv_remote_in)] == ($past(conv_lower_in) & TEMP_LO_MASK))
    else $error("temperature result not captured");

  // Bus writes never reach the results
  result_ro_a: assert property (!conv_done_in |=> $stable(st_q.temp_up) && $stable(st_q.temp_lo))
    else $error("temperature result changed without a conversion");

  // Upper read then lower read of the same channel pairs up; the five idle cycles are the gap that a
  // conversion plus a selector write leaves, and the newer conversion lands inside it
  lower_pair_a: assert property (rd_req_in && rd_addr == A_LT_UP ##1
    (!rd_req_in)[*5] ##1 rd_req_in && rd_addr == A_LT_LO
    |=> rd_data_out == $past(st_q.temp_lo[0], 7))
    else $error("local lower byte not from the paired conversion");

  // Another read ends the pairing
  snap_drop_a: assert property (rd_req_in && rd_addr != A_LT_UP && rd_addr != A_RT_UP
    |=> !st_q.snap_ok)
    else $error("pairing snapshot survived another read");

  // Two-byte read of the remote result
  word_read_a: assert property (rd_req_in && rd_first_in && st_q.sel == A_RT_UP ##1
    rd_req_in && !rd_first_in |=> rd_data_out == $past(st_q.temp_lo[1], 2) && rd_valid_out)
    else $error("two-byte remote read mixed conversions");

  // Third byte of a limit write lands in the lower byte
  pair_write_a: assert property (wr_valid_in && !wr_first_in && st_q.wr_phase == WR_LOWER &&
    st_q.sel == A_LHI_WR |=> reg_q[R_LHI_L] == ($past(wr_data_in) & REG_WMASK[R_LHI_L]))
    else $error("two-byte limit write missed the lower byte");

  // Configuration readback at its read selector
  cfg_read_a: assert property (rd_req_in && rd_addr == A_CFG_RD |=> rd_data_out == $past(reg_q[R_CFG]))
    else $error("configuration readback wrong");

  // One-shot pulses once, only in shutdown
  one_shot_a: assert property (wr_fire && wr_addr == A_ONESHOT
    |=> one_shot_out == $past(reg_q[R_CFG][CFG_SHUTDOWN_BIT]) ##1 !one_shot_out)
    else $error("one-shot pulse wrong");

  // Read answer comes exactly one cycle after the request
  rd_answer_a: assert property (rd_valid_out == $past(rd_req_in))
    else $error("read answer timing wrong");

  // Status read hands the outside flags through and pulses once
  status_pulse_a: assert property (rd_req_in && rd_addr == A_STATUS
    |=> status_read_out && rd_data_out == $past(flag_status_in))
    else $error("status read answer wrong");

  // Writes at read-only places leave every byte register alone
  ro_write_a: assert property (wr_fire && (wr_addr == A_LT_UP || wr_addr == A_RT_UP ||
    wr_addr == A_RT_LO || wr_addr == A_LT_LO || wr_addr == A_STATUS)
    |=> $stable(reg_file_out))
    else $error("write at a read-only place changed a register");

  // One-shot pulse only follows a one-shot write
  shot_idle_a: assert property (!(wr_fire && wr_addr == A_ONESHOT) |=> !one_shot_out)
    else $error("one-shot pulse without a one-shot write");

  // Critical limits and hysteresis take the full byte at their own selector
  crit_write_a: assert property (wr_fire && wr_addr == A_LCRIT
    |=> reg_q[R_LCRIT] == $past(wr_data_in))
    else $error("local critical limit not written");
  rcrit_write_a: assert property (wr_fire && wr_addr == A_RCRIT
    |=> reg_q[R_RCRIT] == $past(wr_data_in))
    else $error("remote critical limit not written");
  hyst_write_a: assert property (wr_fire && wr_addr == A_HYST
    |=> reg_q[R_HYST] == $past(wr_data_in))
    else $error("hysteresis not written");

  // Configuration keeps only its writable bits
  cfg_write_a: assert property (wr_fire && wr_addr == A_CFG_WR
    |=> reg_q[R_CFG] == ($past(wr_data_in) & REG_WMASK[R_CFG]))
    else $error("configuration write wrong");

  // Upper limit byte lands at its write selector
  limit_write_a: assert property (wr_fire && wr_addr == A_RLO_WR
    |=> reg_q[R_RLO_U] == $past(wr_data_in))
    else $error("remote low limit upper byte not written");

  word_read_c: cover property (rd_req_in && rd_first_in && st_q.sel == A_LT_UP ##1 rd_req_in && !rd_first_in);
  pair_write_c: cover property (wr_fire && st_q.wr_phase == WR_LOWER && wr_addr != A_NO_WRITE);
  one_shot_c: cover property (one_shot_out);
  snap_hold_c: cover property (rd_req_in && rd_addr == A_LT_LO && st_q.snap_ok && !st_q.snap_remote);
  conv_between_c: cover property (rd_req_in && rd_addr == A_RT_UP ##1 conv_done_in && conv_remote_in
    ##1 rd_req_in && rd_addr == A_RT_LO);

endmodule
`default_nettype wire

// *** test/tmr_host_model.sv ***
// Bus engine model that issues byte writes and byte reads towards the register file
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model (
  input wire logic mclk_in,
  input wire logic rd_valid_in,
  input wire logic [7:0] rd_data_in,
  output logic wr_valid_out,
  output logic wr_first_out,
  output logic [7:0] wr_data_out,
  output logic rd_req_out,
  output logic rd_first_out
);
  // ************************************************************
  // Idle levels and command tasks
  // ************************************************************
  initial begin
    wr_valid_out = 1'h0;
    wr_first_out = 1'h0;
    wr_data_out = 8'h00;
    rd_req_out = 1'h0;
    rd_first_out = 1'h0;
  end

  // Write command: selector byte, then up to two data bytes, one per cycle
  task automatic wr(input logic [7:0] sel, input int n, input logic [7:0] b0, input logic [7:0] b1);
    @(posedge mclk_in);
    wr_valid_out <= 1'h1;
    wr_first_out <= 1'h1;
    wr_data_out <= sel;
    if (n > 0) begin
      @(posedge mclk_in);
      wr_first_out <= 1'h0;
      wr_data_out <= b0;
    end
    if (n > 1) begin
      @(posedge mclk_in);
      wr_data_out <= b1;
    end
    @(posedge mclk_in);
    wr_valid_out <= 1'h0;
    wr_first_out <= 1'h0;
    // Released data flips so a stale byte can never pass for a fresh one
    wr_data_out <= ~wr_data_out;
  endtask

  // Read command of one or two bytes; the answer is sampled mid-cycle, away from the edge
  task automatic rd(input bit set_sel, input logic [7:0] sel, input int n, output logic [7:0] d0,
    output logic [7:0] d1, output logic ok);
    if (set_sel) begin
      wr(sel, 0, 8'h00, 8'h00);
    end
    @(posedge mclk_in);
    rd_req_out <= 1'h1;
    rd_first_out <= 1'h1;
    @(posedge mclk_in);
    rd_first_out <= 1'h0;
    rd_req_out <= (n > 1);
    @(negedge mclk_in);
    d0 = rd_data_in;
    ok = rd_valid_in;
    d1 = 8'h00;
    if (n > 1) begin
      @(posedge mclk_in);
      rd_req_out <= 1'h0;
      @(negedge mclk_in);
      d1 = rd_data_in;
      ok = ok & rd_valid_in;
    end
  endtask
endmodule
`default_nettype wire

// *** test/test_temp_monitor_register_map.sv ***
// Self-checking bench of the temperature monitor register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_temp_monitor_register_map;
  import tmr_pkg::*;
  // ************************************************************
  // Signals, tables and instances
  // ************************************************************
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] PART = 8'hC3; // Arbitrary value
  localparam logic [7:0] RST_A [18] = '{8'h00, 8'h01, 8'h10, 8'h15, 8'h05, 8'h16, 8'h06, 8'h17, 8'h07,
    8'h13, 8'h08, 8'h14, 8'h19, 8'h20, 8'h21, 8'h03, 8'hFE, 8'hFF};
  localparam logic [7:0] RST_V [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h55,
    8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0A, 8'h00, MAKER, PART};
  localparam logic [7:0] LIM_W [4] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E};
  localparam logic [7:0] LIM_R [4] = '{8'h05, 8'h06, 8'h07, 8'h08};
  localparam logic [7:0] LIM_L [4] = '{8'h16, 8'h17, 8'h13, 8'h14};
  logic mclk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic conv_done = 1'h0;
  logic conv_remote = 1'h0;
  logic [7:0] conv_upper = 8'h00;
  logic [7:0] conv_lower = 8'h00;
  logic [7:0] flag_status = 8'h00;
  logic wr_valid, wr_first, rd_req, rd_first, rd_valid, one_shot, status_read, shutdown, range_sel;
  logic [7:0] wr_data, rd_data, d0, d1;
  logic [NREG*8-1:0] reg_file;
  logic ok;
  int n_fail = 0;
  int num_checks = 0;
  int n_shot = 0;
  int n_stat = 0;
  int s;

  tmr_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) uut (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .wr_valid_in(wr_valid), .wr_first_in(wr_first), .wr_data_in(wr_data), .rd_req_in(rd_req),
    .rd_first_in(rd_first), .conv_done_in(conv_done), .conv_remote_in(conv_remote),
    .conv_upper_in(conv_upper), .conv_lower_in(conv_lower), .flag_status_in(flag_status),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid), .one_shot_out(one_shot),
    .status_read_out(status_read), .shutdown_bit_out(shutdown), .range_out(range_sel),
    .reg_file_out(reg_file));
  tmr_host_model host (.mclk_in(mclk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
    .wr_valid_out(wr_valid), .wr_first_out(wr_first), .wr_data_out(wr_data), .rd_req_out(rd_req),
    .rd_first_out(rd_first));

  // Clock and pulse counters; pre-edge values are read, so no race with the design
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (one_shot === 1'h1) n_shot++;
    if (status_read === 1'h1) n_stat++;
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic conv(input logic rem, input logic [7:0] up, input logic [7:0] lo);
    @(posedge mclk_in);
    conv_done <= 1'h1;
    conv_remote <= rem;
    conv_upper <= up;
    conv_lower <= lo;
    @(posedge mclk_in);
    conv_done <= 1'h0;
  endtask

  // A bare read first: the selector must still be zero from reset
  task automatic t_reset();
    host.rd(0, 8'h00, 1, d0, d1, ok);
    `CHK("bare read", 8'h00, d0);
    `CHK("hysteresis byte", 8'h0A, reg_file[R_HYST*8+:8]);
    for (int i = 0; i < 18; i++) begin
      host.rd(1, RST_A[i], 1, d0, d1, ok);
      `CHK("reset value", RST_V[i], d0);
    end
  endtask

  // Two-byte writes, two-byte reads, then a lone lower-byte rewrite
  task automatic t_limits();
    for (int i = 0; i < 4; i++) begin
      host.wr(LIM_W[i], 2, 8'hA0 | 8'(i), 8'h9F);
      host.rd(1, LIM_R[i], 2, d0, d1, ok);
      `CHK("limit upper", 8'hA0 | 8'(i), d0);
      `CHK("limit lower", 8'h90, d1);
      `CHK("read valid", 1'h1, ok);
      host.wr(LIM_L[i], 1, 8'h5F, 8'h00);
      host.rd(1, LIM_R[i], 2, d0, d1, ok);
      `CHK("lower rewrite", 8'h50, d1);
    end
  endtask

  task automatic t_crit();
    host.wr(8'h20, 1, 8'h7E, 8'h00);
    host.wr(8'h19, 1, 8'h66, 8'h00);
    host.wr(8'h21, 1, 8'h05, 8'h00);
    host.rd(1, 8'h20, 1, d0, d1, ok);
    `CHK("local critical", 8'h7E, d0);
    host.rd(1, 8'h19, 1, d0, d1, ok);
    `CHK("remote critical", 8'h66, d0);
    host.rd(1, 8'h21, 1, d0, d1, ok);
    `CHK("hysteresis", 8'h05, d0);
  endtask

  // Range and shutdown on, limits untouched, one-shot only counts in shutdown
  task automatic t_config();
    host.wr(8'h09, 1, 8'h44, 8'h00);
    host.rd(1, 8'h03, 1, d0, d1, ok);
    `CHK("config", 8'h44, d0);
    `CHK("shutdown level", 1'h1, shutdown);
    `CHK("range level", 1'h1, range_sel);
    host.rd(1, 8'h05, 1, d0, d1, ok);
    `CHK("limit after range", 8'hA0, d0);
    s = n_shot;
    host.wr(8'h0F, 1, 8'hFF, 8'h00);
    repeat (3) @(posedge mclk_in);
    `CHK("one shot count", s + 1, n_shot);
    host.wr(8'h09, 1, 8'h00, 8'h00);
    host.wr(8'h0F, 1, 8'hFF, 8'h00);
    repeat (3) @(posedge mclk_in);
    `CHK("one shot running", s + 1, n_shot);
  endtask

  // Snapshot kept across a newer conversion, dropped after another read
  task automatic t_conv();
    conv(1'h0, 8'h19, 8'h5F);
    host.rd(1, 8'h00, 1, d0, d1, ok);
    `CHK("local upper", 8'h19, d0);
    conv(1'h0, 8'h1A, 8'h80);
    host.rd(1, 8'h15, 1, d0, d1, ok);
    `CHK("local snapshot", 8'h50, d0);
    host.rd(1, 8'h01, 1, d0, d1, ok);
    host.rd(1, 8'h15, 1, d0, d1, ok);
    `CHK("local current", 8'h80, d0);
    conv(1'h1, 8'h2B, 8'hC7);
    host.rd(1, 8'h01, 2, d0, d1, ok);
    `CHK("remote upper", 8'h2B, d0);
    `CHK("remote lower", 8'hC0, d1);
  endtask

  // Writes at read-only places change nothing; write-only place reads zero
  task automatic t_readonly();
    foreach (RST_A[i]) begin
      if (i < 4) host.wr(RST_A[i], 1, 8'hEE, 8'h00);
    end
    host.wr(8'h02, 1, 8'hEE, 8'h00);
    host.rd(1, 8'h00, 2, d0, d1, ok);
    `CHK("local after write", 8'h1A, d0);
    `CHK("local lower after write", 8'h80, d1);
    host.rd(1, 8'h10, 1, d0, d1, ok);
    `CHK("remote lower after write", 8'hC0, d0);
    host.rd(1, 8'h0F, 1, d0, d1, ok);
    `CHK("write-only read", 8'h00, d0);
    @(posedge mclk_in);
    flag_status <= 8'h3C;
    s = n_stat;
    host.rd(1, 8'h02, 1, d0, d1, ok);
    repeat (2) @(posedge mclk_in);
    `CHK("status byte", 8'h3C, d0);
    `CHK("status pulse", s + 1, n_stat);
  endtask

  // ************************************************************
  // Verdict, watchdog and main sequence
  // ************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The tests take a few hundred cycles; 20000 cycles means a hang
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'h1;
    t_reset();
    t_limits();
    t_crit();
    t_config();
    t_conv();
    t_readonly();
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
